// ---- hdl/sg_dma_device.sv ----
// Purpose: scatter-gather packet dma engine, one host_to_card, one card_to_host channel
// Assumes: host answers memory requests one cycle after the request
// Notes: one descriptor is executed at a time, channels taken in turn
// Contract
// - dma registers low half, user registers high
// - each channel has separate registers
// - descriptor is eight words, 32 bytes
// - packets may span chained descriptors
// - start flag: software on tx, device on rx
// - end flag: software on tx, device on rx
// - error flag set on failed descriptor
// - short flag when fewer bytes moved
// - done flag set when descriptor finishes
// - rx flags for zero user status halves
// - interrupt on error when bit set
// - interrupt on completion when bit set
// - transfer_length queued, rx overwrites actual count
// - buffer_capacity_length bounds rx buffer use
// - user control shown with tx packet start
// - system address locates buffer data
// - next pointer links 32-byte aligned descriptors
// - ring registers, fetch descriptor then data
// - tx status word rewritten with done set
// - rx prefetch, write data, update status
// - user status sampled at end only
// - software advances end address regularly
`timescale 1ns/1ps
module sync_fifo import sg_dma_pkg::*; #(
	parameter int WIDTH = TXF_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;
	// depth must be a power of two so the pointers wrap by themselves
	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_r[rd_ptr_r];
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge mclk) begin
		if (push) mem_r[wr_ptr_r] <= in_data;
	end
endmodule : sync_fifo

module sg_dma_device import sg_dma_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	sg_dma_if.dev link,
	output logic user_reg_strobe,
	output logic user_reg_we,
	output logic [REG_AW-2:0] user_reg_addr,
	output logic [WORD_W-1:0] user_reg_wdata,
	input wire logic [WORD_W-1:0] user_reg_rdata,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [WORD_W-1:0] tx_data,
	output logic tx_stream_packet_start,
	output logic tx_stream_packet_end,
	output logic [1:0] tx_valid_bytes,
	output logic [USER_W-1:0] tx_user_ctrl,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [WORD_W-1:0] rx_data,
	input wire logic rx_stream_packet_end,
	input wire logic [1:0] rx_valid_bytes,
	input wire logic [USER_W-1:0] rx_user_status
);
	logic rbusy_r, rphase_r, r_we_r, ack_r, ustb_r, r_ch, r_low, reg_wr;
	logic [REG_AW-1:0] r_addr_r;
	logic [WORD_W-1:0] r_wdata_r, rdata_r, dma_rdata;
	logic [NUM_CH-1:0] en_r, avail;
	logic [WORD_W-1:0] start_r [NUM_CH];
	logic [WORD_W-1:0] end_r [NUM_CH];
	logic [WORD_W-1:0] cur_r [NUM_CH];
	logic [CNT_W-1:0] done_cnt_r [NUM_CH];
	dma_state_e state_r;
	logic ch_r, last_ch_r, err_r, end_seen_r, in_pkt_r, irq_r, adv, sel, tx_last;
	logic [2:0] idx_r;
	logic [LEN_W-1:0] wcnt_r, bytes_r, len, cap, tx_words, bytes_sum;
	logic [USER_W-1:0] ustat_r;
	logic [WORD_W-1:0] desc_r [DESC_WORDS];
	logic [WORD_W-1:0] base, status_word;
	logic f_ready;
	logic [TXF_W-1:0] f_in, f_out;

	function automatic logic [WORD_W-1:0] desc_word(input logic [WORD_W-1:0] b,
			input logic [2:0] i);
		return {b[WORD_W-1:DESC_ALIGN], i, {WORD_LSB{1'b0}}};
	endfunction : desc_word

	function automatic logic [LEN_W-1:0] bytes_of(input logic [1:0] code);
		return (code == 2'h0) ? WORD_BYTES : {{(LEN_W-2){1'b0}}, code};
	endfunction : bytes_of

	// register slave: dma half answers two cycles after the request, user half one later
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rbusy_r <= 1'b0;
			rphase_r <= 1'b0;
			r_we_r <= 1'b0;
			ack_r <= 1'b0;
			ustb_r <= 1'b0;
			r_addr_r <= '0;
			r_wdata_r <= '0;
			rdata_r <= '0;
		end else begin
			ack_r <= 1'b0;
			ustb_r <= 1'b0;
			if (!rbusy_r) begin
				if (link.reg_req) begin
					rbusy_r <= 1'b1;
					rphase_r <= 1'b0;
					r_we_r <= link.reg_we;
					r_addr_r <= link.reg_addr;
					r_wdata_r <= link.reg_wdata;
				end
			end else if (ack_r) begin
				rbusy_r <= 1'b0;
			end else if (!rphase_r) begin
				if (r_addr_r > DMA_LAST) begin
					ustb_r <= 1'b1;
					rphase_r <= 1'b1;
				end else begin
					ack_r <= 1'b1;
					rdata_r <= r_we_r ? '0 : dma_rdata;
				end
			end else if (ustb_r) begin
				ack_r <= 1'b1;
				rdata_r <= r_we_r ? '0 : user_reg_rdata;
			end
		end
	end
	assign link.reg_ack = ack_r;
	assign link.reg_rdata = rdata_r;
	assign user_reg_strobe = ustb_r;
	assign user_reg_we = r_we_r;
	assign user_reg_addr = r_addr_r[REG_AW-2:0];
	assign user_reg_wdata = r_wdata_r;
	assign r_ch = r_addr_r[CH_SEL_BIT];
	assign r_low = (r_addr_r[REG_AW-1:CH_SEL_BIT+1] == MAP_HI_ZERO);
	assign reg_wr = rbusy_r && !ack_r && !rphase_r && r_we_r && r_low;

	// read mux, unmapped dma addresses read zero
	always_comb begin
		dma_rdata = '0;
		if (r_low) begin
			case (r_addr_r[CH_SEL_BIT-1:0])
				REG_CTRL: dma_rdata[CTRL_EN_BIT] = en_r[r_ch];
				REG_START: dma_rdata = start_r[r_ch];
				REG_END: dma_rdata = end_r[r_ch];
				REG_CUR: dma_rdata = cur_r[r_ch];
				REG_DONE: dma_rdata = {{(WORD_W-CNT_W){1'b0}}, done_cnt_r[r_ch]};
				default: dma_rdata = '0;
			endcase
		end
	end

	// per-channel ring state; a descriptor error halts its channel
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			en_r <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				start_r[c] <= '0;
				end_r[c] <= '0;
				cur_r[c] <= '0;
				done_cnt_r[c] <= '0;
			end
		end else begin
			if (adv) begin
				cur_r[ch_r] <= {desc_r[DW_NEXT][WORD_W-1:DESC_ALIGN], {DESC_ALIGN{1'b0}}};
				done_cnt_r[ch_r] <= done_cnt_r[ch_r] + 1'b1;
				if (err_r) en_r[ch_r] <= 1'b0;
			end
			if (reg_wr) begin
				case (r_addr_r[CH_SEL_BIT-1:0])
					REG_CTRL: begin
						en_r[r_ch] <= r_wdata_r[CTRL_EN_BIT];
						if (r_wdata_r[CTRL_EN_BIT] && !en_r[r_ch]) cur_r[r_ch] <= start_r[r_ch];
					end
					REG_START: start_r[r_ch] <= r_wdata_r;
					REG_END: end_r[r_ch] <= r_wdata_r;
					default: ;
				endcase
			end
		end
	end

	// a channel has work while its pointer has not met the end address
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			avail[c] = en_r[c] && (cur_r[c] != end_r[c]);
		end
	end
	assign sel = (&avail) ? !last_ch_r : avail[CARD_TO_HOST];
	assign base = cur_r[ch_r];
	assign len = desc_r[DW_STATUS][LEN_W-1:0];
	assign cap = desc_r[DW_CTRL][LEN_W-1:0];
	assign tx_words = {2'b00, len[LEN_W-1:WORD_LSB]} + {{(LEN_W-1){1'b0}}, |len[1:0]};
	assign tx_last = (wcnt_r == tx_words - LEN_ONE);
	assign bytes_sum = bytes_r + bytes_of(rx_valid_bytes);
	assign adv = (state_r == ST_WRSTAT) && link.mem_ack;

	// descriptor engine; ch_r high means the card_to_host channel
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			ch_r <= 1'b0;
			last_ch_r <= 1'b1;
			idx_r <= '0;
			wcnt_r <= '0;
			bytes_r <= '0;
			err_r <= 1'b0;
			end_seen_r <= 1'b0;
			in_pkt_r <= 1'b0;
			ustat_r <= '0;
			for (int i = 0; i < DESC_WORDS; i++) desc_r[i] <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (|avail) begin
						ch_r <= sel;
						last_ch_r <= sel;
						state_r <= ST_FETCH;
						idx_r <= '0;
						wcnt_r <= '0;
						bytes_r <= '0;
						err_r <= 1'b0;
						end_seen_r <= 1'b0;
					end
				end
				ST_FETCH: begin
					if (link.mem_ack) begin
						desc_r[idx_r] <= link.mem_rdata;
						if (link.mem_err) err_r <= 1'b1;
						if (idx_r != DW_NEXT) idx_r <= idx_r + 3'h1;
						else if (err_r || link.mem_err) state_r <= ST_WRSTAT;
						else if (ch_r) state_r <= ST_RXDATA;
						else if (tx_words == '0) state_r <= ST_WRSTAT;
						else state_r <= ST_TXDATA;
					end
				end
				ST_TXDATA: begin
					if (link.mem_ack) begin
						// a failed read moves nothing, so the word is not counted
						if (!link.mem_err) wcnt_r <= wcnt_r + LEN_ONE;
						if (link.mem_err) err_r <= 1'b1;
						if (link.mem_err || tx_last) state_r <= ST_WRSTAT;
					end
				end
				ST_RXDATA: begin
					if (link.mem_ack) begin
						bytes_r <= bytes_sum;
						if (link.mem_err) err_r <= 1'b1;
						if (rx_stream_packet_end) begin
							end_seen_r <= 1'b1;
							ustat_r <= rx_user_status;
							idx_r <= '0;
							state_r <= link.mem_err ? ST_WRSTAT : ST_WRUSR;
						end else if (link.mem_err || bytes_sum >= cap) begin
							state_r <= ST_WRSTAT;
						end
					end
				end
				ST_WRUSR: begin
					if (link.mem_ack) begin
						if (idx_r[0]) state_r <= ST_WRSTAT;
						else idx_r <= idx_r + 3'h1;
					end
				end
				ST_WRSTAT: begin
					if (link.mem_ack) begin
						state_r <= ST_IDLE;
						if (ch_r) in_pkt_r <= !end_seen_r;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// written-back status and byte count word
	always_comb begin
		status_word = '0;
		status_word[DESCRIPTOR_DONE_FLAG] = 1'b1;
		status_word[ERROR_FLAG] = err_r;
		if (ch_r) begin
			status_word[LEN_W-1:0] = bytes_r;
			status_word[PACKET_START_FLAG] = !in_pkt_r;
			status_word[PACKET_END_FLAG] = end_seen_r;
			status_word[SHORT_TRANSFER_FLAG] = (bytes_r < cap);
			status_word[USER_STATUS_UPPER_ZERO] = end_seen_r && (ustat_r[USER_W-1:HALF_W] == '0);
			status_word[USER_STATUS_LOWER_ZERO] = end_seen_r && (ustat_r[HALF_W-1:0] == '0);
		end else begin
			status_word[LEN_W-1:0] = len;
			status_word[PACKET_START_FLAG] = desc_r[DW_CTRL][PACKET_START_FLAG];
			status_word[PACKET_END_FLAG] = desc_r[DW_CTRL][PACKET_END_FLAG];
			status_word[SHORT_TRANSFER_FLAG] = (wcnt_r != tx_words);
		end
	end

	// memory requests held until the host acknowledges
	always_comb begin
		link.mem_req = 1'b0;
		link.mem_we = 1'b0;
		link.mem_addr = '0;
		link.mem_wdata = '0;
		case (state_r)
			ST_FETCH: begin
				link.mem_req = 1'b1;
				link.mem_addr = desc_word(base, idx_r);
			end
			ST_TXDATA: begin
				link.mem_req = f_ready; // fifo full stalls the fetch
				link.mem_addr = desc_r[DW_SYS] + {{(WORD_W-LEN_W-WORD_LSB){1'b0}}, wcnt_r,
					{WORD_LSB{1'b0}}};
			end
			ST_RXDATA: begin
				link.mem_req = rx_valid;
				link.mem_we = 1'b1;
				link.mem_addr = desc_r[DW_SYS] + {{(WORD_W-LEN_W){1'b0}}, bytes_r};
				link.mem_wdata = rx_data;
			end
			ST_WRUSR: begin
				link.mem_req = 1'b1;
				link.mem_we = 1'b1;
				link.mem_addr = desc_word(base, DW_USER_LO + idx_r);
				link.mem_wdata = idx_r[0] ? ustat_r[USER_W-1:HALF_W] : ustat_r[HALF_W-1:0];
			end
			ST_WRSTAT: begin
				link.mem_req = 1'b1;
				link.mem_we = 1'b1;
				link.mem_addr = desc_word(base, DW_STATUS);
				link.mem_wdata = status_word;
			end
			default: ;
		endcase
	end
	assign rx_ready = (state_r == ST_RXDATA) && link.mem_ack;

	// interrupt pulse once the status word is written
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) irq_r <= 1'b0;
		else irq_r <= adv && (desc_r[DW_CTRL][INTERRUPT_ON_DONE_BIT]
			|| (err_r && desc_r[DW_CTRL][INTERRUPT_ON_ERROR_BIT]));
	end
	assign link.irq = irq_r;

	// tx words: user control rides with the first word of a packet
	assign f_in = {
		(desc_r[DW_CTRL][PACKET_START_FLAG] && wcnt_r == '0) ?
			{desc_r[DW_USER_HI], desc_r[DW_USER_LO]} : {USER_W{1'b0}},
		desc_r[DW_CTRL][PACKET_START_FLAG] && (wcnt_r == '0),
		desc_r[DW_CTRL][PACKET_END_FLAG] && tx_last,
		tx_last ? len[1:0] : 2'b00,
		link.mem_rdata
	};
	sync_fifo #(.WIDTH(TXF_W), .DEPTH(FIFO_DEPTH)) tx_buf (
		.mclk(mclk),
		.resetn(resetn),
		.in_valid((state_r == ST_TXDATA) && link.mem_ack && !link.mem_err),
		.in_ready(f_ready),
		.in_data(f_in),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(f_out)
	);
	assign tx_user_ctrl = f_out[TXF_W-1:TXF_W-USER_W];
	assign tx_stream_packet_start = f_out[WORD_W+3];
	assign tx_stream_packet_end = f_out[WORD_W+2];
	assign tx_valid_bytes = f_out[WORD_W+1:WORD_W];
	assign tx_data = f_out[WORD_W-1:0];
endmodule : sg_dma_device

// ---- hdl/sg_dma_pkg.sv ----
// Purpose: shared constants and types for the scatter-gather packet dma pair
// Assumes: one clock, 32-bit register and memory words, byte addresses
// Notes: descriptor bit positions are common to both ends
package sg_dma_pkg;
	localparam int REG_AW = 16;
	localparam int WORD_W = 32;
	localparam int WORD_LSB = 2;
	localparam int NUM_CH = 2;
	localparam int HOST_TO_CARD = 0;
	localparam int CARD_TO_HOST = 1;
	localparam int LEN_W = 20;
	localparam int USER_W = 64;
	localparam int HALF_W = 32;
	localparam int CNT_W = 16;
	// bar window: dma registers below, user registers from here up
	localparam logic [REG_AW-1:0] USER_BASE = 16'h8000;
	localparam logic [REG_AW-1:0] DMA_LAST = 16'h7FFF;
	localparam int CH_SEL_BIT = 8;
	localparam logic [6:0] MAP_HI_ZERO = 7'h00;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_START = 8'h04;
	localparam logic [7:0] REG_END = 8'h08;
	localparam logic [7:0] REG_CUR = 8'h0C;
	localparam logic [7:0] REG_DONE = 8'h10;
	localparam int CTRL_EN_BIT = 0;
	// descriptor: eight words, 32-byte aligned
	localparam int DESC_WORDS = 8;
	localparam int DESC_ALIGN = 5;
	localparam logic [2:0] DW_STATUS = 3'h0;
	localparam logic [2:0] DW_CTRL = 3'h1;
	localparam logic [2:0] DW_USER_LO = 3'h2;
	localparam logic [2:0] DW_USER_HI = 3'h3;
	localparam logic [2:0] DW_SYS = 3'h5;
	localparam logic [2:0] DW_NEXT = 3'h6;
	// status word bits, transfer_length in the low LEN_W bits
	localparam int PACKET_START_FLAG = 31;
	localparam int PACKET_END_FLAG = 30;
	localparam int ERROR_FLAG = 29;
	localparam int SHORT_TRANSFER_FLAG = 28;
	localparam int DESCRIPTOR_DONE_FLAG = 27;
	localparam int USER_STATUS_UPPER_ZERO = 26;
	localparam int USER_STATUS_LOWER_ZERO = 25;
	// control word bits, buffer_capacity_length in the low LEN_W bits
	localparam int INTERRUPT_ON_ERROR_BIT = 25;
	localparam int INTERRUPT_ON_DONE_BIT = 24;
	localparam logic [LEN_W-1:0] LEN_ONE = 20'h00001;
	localparam logic [LEN_W-1:0] WORD_BYTES = 20'h00004;
	localparam int FIFO_DEPTH = 16;
	localparam int TXF_W = USER_W + 4 + WORD_W;
	localparam int MEM_AW = 10;
	localparam int HOST_WORDS = 1024;
	localparam int MEM_SPAN = 12;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_TXDATA = 3'b010,
		ST_RXDATA = 3'b011,
		ST_WRUSR = 3'b100,
		ST_WRSTAT = 3'b101
	} dma_state_e;
endpackage : sg_dma_pkg

// ---- hdl/sg_dma_if.sv ----
// Purpose: link between the dma device end and the host end
// Assumes: both ends on mclk
// Notes: register access host to device, memory access device to host
`timescale 1ns/1ps
interface sg_dma_if;
	import sg_dma_pkg::*;
	logic reg_req;
	logic reg_we;
	logic [REG_AW-1:0] reg_addr;
	logic [WORD_W-1:0] reg_wdata;
	logic reg_ack;
	logic [WORD_W-1:0] reg_rdata;
	logic mem_req;
	logic mem_we;
	logic [WORD_W-1:0] mem_addr;
	logic [WORD_W-1:0] mem_wdata;
	logic mem_ack;
	logic mem_err;
	logic [WORD_W-1:0] mem_rdata;
	logic irq;
	modport dev (
		input reg_req, reg_we, reg_addr, reg_wdata, mem_ack, mem_err, mem_rdata,
		output reg_ack, reg_rdata, mem_req, mem_we, mem_addr, mem_wdata, irq
	);
	modport host (
		output reg_req, reg_we, reg_addr, reg_wdata, mem_ack, mem_err, mem_rdata,
		input reg_ack, reg_rdata, mem_req, mem_we, mem_addr, mem_wdata, irq
	);
endinterface : sg_dma_if

// ---- hdl/sg_dma_host.sv ----
// Purpose: host end: bar access master and host memory for the dma
// Assumes: memory answers one cycle after each request
// Notes: addresses beyond the memory span answer with an error
`timescale 1ns/1ps
module sg_dma_host import sg_dma_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	sg_dma_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_we,
	input wire logic [REG_AW-1:0] cmd_addr,
	input wire logic [WORD_W-1:0] cmd_wdata,
	output logic cmd_done,
	output logic [WORD_W-1:0] cmd_rdata,
	input wire logic bd_we,
	input wire logic [MEM_AW-1:0] bd_addr,
	input wire logic [WORD_W-1:0] bd_wdata,
	output logic [WORD_W-1:0] bd_rdata,
	output logic irq_seen
);
	logic [WORD_W-1:0] mem_r [HOST_WORDS];
	logic req_r, we_r, done_r, ack_r, err_r, irq_r, in_range, first;
	logic [REG_AW-1:0] addr_r;
	logic [WORD_W-1:0] wdata_r, rdata_r, mrdata_r, bdr_r;
	logic [MEM_AW-1:0] midx;

	assign in_range = (link.mem_addr[WORD_W-1:MEM_SPAN] == '0);
	assign midx = link.mem_addr[MEM_SPAN-1:WORD_LSB];
	assign first = link.mem_req && !ack_r;

	// memory answer, one acknowledge per request
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
			mrdata_r <= '0;
		end else begin
			ack_r <= first;
			err_r <= first && !in_range;
			mrdata_r <= in_range ? mem_r[midx] : '0;
		end
	end

	// descriptors and buffers, word addressed; a dma write wins over the backdoor
	always_ff @(posedge mclk) begin
		if (first && link.mem_we && in_range) mem_r[midx] <= link.mem_wdata;
		else if (bd_we) mem_r[bd_addr] <= bd_wdata;
		bdr_r <= mem_r[bd_addr];
	end
	assign link.mem_ack = ack_r;
	assign link.mem_err = err_r;
	assign link.mem_rdata = mrdata_r;
	assign bd_rdata = bdr_r;

	// register commands held on the link until acknowledged
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			req_r <= 1'b0;
			we_r <= 1'b0;
			done_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= '0;
			rdata_r <= '0;
		end else begin
			done_r <= 1'b0;
			if (!req_r && !done_r && cmd_valid) begin
				req_r <= 1'b1;
				we_r <= cmd_we;
				addr_r <= cmd_addr;
				wdata_r <= cmd_wdata;
			end else if (req_r && link.reg_ack) begin
				req_r <= 1'b0;
				done_r <= 1'b1;
				rdata_r <= link.reg_rdata;
			end
		end
	end
	assign cmd_ready = !req_r && !done_r;
	assign cmd_done = done_r;
	assign cmd_rdata = rdata_r;
	assign link.reg_req = req_r;
	assign link.reg_we = we_r;
	assign link.reg_addr = addr_r;
	assign link.reg_wdata = wdata_r;

	// interrupt pulse seen by software
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) irq_r <= 1'b0;
		else irq_r <= link.irq;
	end
	assign irq_seen = irq_r;
endmodule : sg_dma_host

// ---- sim/sg_dma_sva.sv ----
// Purpose: link protocol checks for the dma device and host ends
// Assumes: one clock, async active-low reset
// Notes: sees the interface signals only
`timescale 1ns/1ps
module sg_dma_sva import sg_dma_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic reg_req,
	input wire logic reg_we,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic reg_ack,
	input wire logic [WORD_W-1:0] reg_rdata,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [WORD_W-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic mem_err,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// dma half answers in two cycles, user half one later
	dma_ack_time_a: assert property ($rose(reg_req) && !reg_addr[15] |-> !reg_ack[*2] ##1 reg_ack)
		else $error("dma register ack not two cycles after request");
	user_ack_time_a: assert property ($rose(reg_req) && reg_addr[15] |-> !reg_ack[*3] ##1 reg_ack)
		else $error("user register ack not three cycles after request");
	write_rdata_zero_a: assert property (reg_ack && reg_we |-> reg_rdata == '0)
		else $error("write ack carries read data");
	// request and address must not move before the answer
	mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request dropped or changed early");
	mem_answer_a: assert property ($rose(mem_req) |=> mem_ack)
		else $error("memory answer not one cycle after request");
	word_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
		else $error("memory address not word aligned");
	mem_err_range_a: assert property (mem_ack |-> mem_err == (mem_addr >= 32'h00001000))
		else $error("memory error does not match address range");
	// interrupt only right after a descriptor status write lands
	irq_cause_a: assert property (irq |-> $past(mem_ack && mem_we) ##1 !irq)
		else $error("interrupt without status write or longer than a cycle");
endmodule : sg_dma_sva

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the dma device and host ends
// Assumes: engine idle during backdoor writes
// Notes: tx sink stalls at random, rx source is the bench
`timescale 1ns/1ps
module tb_top import sg_dma_pkg::*;;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid = 1'b0, cmd_we = 1'b0, bd_we = 1'b0, tx_ready = 1'b0, stall = 1'b1;
	logic rx_valid = 1'b0, rx_eop = 1'b0, cmd_ready, cmd_done, irq_seen, ustb, uwe, rx_ready;
	logic tx_valid, tx_sop, tx_eop;
	logic [1:0] tx_vb, rx_vb = 2'h0;
	logic [WORD_W:0] uw;
	logic [REG_AW-1:0] cmd_addr = '0;
	logic [REG_AW-2:0] uaddr, ua;
	logic [MEM_AW-1:0] bd_addr = '0;
	logic [WORD_W-1:0] cmd_wdata = '0, bd_wdata = '0, usr_rd = '0, rx_data = '0;
	logic [WORD_W-1:0] cmd_rdata, bd_rdata, tx_data, uwd, q, ex[19], rw[3];
	logic [USER_W-1:0] tx_uc, rx_us = '0, uc;
	logic [USER_W+WORD_W+3:0] txq[$];
	logic [31:0] seed = 32'h00000053;
	int bad_count = 0, comparisons = 0, irqs = 0, i;
	sg_dma_if link();
	sg_dma_device u_sg_dma_device (.mclk(mclk), .resetn(resetn), .link(link.dev),
		.user_reg_strobe(ustb), .user_reg_we(uwe), .user_reg_addr(uaddr), .user_reg_wdata(uwd),
		.user_reg_rdata(usr_rd), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_stream_packet_start(tx_sop), .tx_stream_packet_end(tx_eop), .tx_valid_bytes(tx_vb),
		.tx_user_ctrl(tx_uc), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.rx_stream_packet_end(rx_eop), .rx_valid_bytes(rx_vb), .rx_user_status(rx_us));
	sg_dma_host u_sg_dma_host (.mclk(mclk), .resetn(resetn), .link(link.host),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_we(cmd_we), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata), .bd_we(bd_we),
		.bd_addr(bd_addr), .bd_wdata(bd_wdata), .bd_rdata(bd_rdata), .irq_seen(irq_seen));
	sg_dma_sva u_sg_dma_sva (.mclk(mclk), .resetn(resetn), .reg_req(link.reg_req),
		.reg_we(link.reg_we), .reg_addr(link.reg_addr), .reg_ack(link.reg_ack),
		.reg_rdata(link.reg_rdata), .mem_req(link.mem_req), .mem_we(link.mem_we),
		.mem_addr(link.mem_addr), .mem_ack(link.mem_ack), .mem_err(link.mem_err), .irq(link.irq));
	initial forever #5 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// status word: start, end, err, short, done, upper zero, lower zero, then length
	function automatic logic [31:0] st(input logic [6:0] f, input logic [19:0] n);
		return {f, 5'h00, n};
	endfunction : st
	// outputs sampled at the falling edge, where they are settled
	always @(negedge mclk) begin
		if (irq_seen === 1'b1) irqs++;
		if (ustb === 1'b1) begin
			ua <= uaddr;
			uw <= {uwe, uwd};
		end
		if (tx_valid === 1'b1 && tx_ready)
			txq.push_back({tx_vb, tx_sop, tx_eop, tx_uc, tx_data});
	end
	// stream sink with random backpressure, held off entirely while stall is set
	always @(posedge mclk) tx_ready <= #1 !stall && rnd() % 3 != 0;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task rg(input logic we, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		#1 cmd_valid = 1'b1;
		cmd_we = we;
		cmd_addr = a;
		cmd_wdata = d;
		@(posedge mclk);
		#1 cmd_valid = 1'b0;
		cmd_wdata = ~d;
		for (n = 0; n < 20 && cmd_done !== 1'b1; n++) @(posedge mclk) #1;
		q = cmd_rdata;
		if (n == 20) bad_count++;
	endtask : rg
	task mw(input int a, input logic [31:0] d);
		@(posedge mclk);
		#1 bd_we = 1'b1;
		bd_addr = a[MEM_AW+1:2];
		bd_wdata = d;
		@(posedge mclk);
		#1 bd_we = 1'b0;
	endtask : mw
	task mr(input int a);
		@(posedge mclk);
		#1 bd_addr = a[MEM_AW+1:2];
		@(posedge mclk);
		#1 q = bd_rdata;
	endtask : mr
	task desc(input int b, input logic [31:0] w0, w1, w2, w3, sa, nx);
		logic [31:0] d[8];
		d = '{w0, w1, w2, w3, 32'h0, sa, nx, 32'h0};
		for (int k = 0; k < 8; k++) mw(b + 4 * k, d[k]);
	endtask : desc
	task poll(input logic [15:0] a, input logic [31:0] n);
		for (int k = 0; k < 300 && q !== n; k++) rg(1'b0, a, 32'h0);
	endtask : poll
	task send(input logic [31:0] d, input logic e);
		int n;
		@(posedge mclk);
		#1 rx_valid = 1'b1;
		rx_data = d;
		rx_eop = e;
		rx_vb = e ? 2'h3 : 2'h0;
		// ready seen settled in its cycle, word taken at the edge that ends it
		for (n = 0; n < 500 && rx_ready !== 1'b1; n++) @(posedge mclk) #1;
		@(posedge mclk);
		#1 rx_valid = 1'b0;
		rx_eop = 1'b0;
		rx_data = ~d;
		if (n == 500) bad_count++;
	endtask : send
	task end_of_test;
		$display("%0d comparisons, %0d mismatches", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	initial begin
		#400000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge mclk);
		#1 resetn = 1'b1;
		// register map: separate pages, read-only and reserved places, user half
		rg(1'b1, 16'h0004, 32'h00000100);
		rg(1'b1, 16'h0104, 32'h00000200);
		rg(1'b0, 16'h0004, 32'h0); chk(q, 32'h00000100);
		rg(1'b0, 16'h0104, 32'h0); chk(q, 32'h00000200);
		rg(1'b1, 16'h000C, 32'h12345678);
		rg(1'b0, 16'h000C, 32'h0); chk(q, 32'h0);
		rg(1'b1, 16'h0300, 32'hFFFFFFFF);
		rg(1'b0, 16'h0300, 32'h0); chk(q, 32'h0);
		usr_rd = rnd();
		rg(1'b0, 16'hC010, 32'h0); chk(q, usr_rd);
		chk({17'h0, ua}, 32'h00004010);
		rg(1'b1, 16'h8008, 32'h5A5A0F0F); chk(uw[31:0], 32'h5A5A0F0F);
		chk({31'h0, uw[32]}, 32'h1);
		$display("register test done");
		// tx: 18-word start descriptor overfills the fifo, chained to a one-word end
		uc = {rnd(), rnd()};
		for (i = 0; i < 19; i++) ex[i] = rnd();
		for (i = 0; i < 19; i++) mw(32'h400 + 4 * i + (i == 18 ? 32'h70 : 32'h0), ex[i]);
		desc(32'h100, 32'd72, 32'h80000048, uc[31:0], uc[63:32], 32'h400, 32'h120);
		desc(32'h120, 32'd3, 32'h41000004, 32'h0, 32'h0, 32'h4B8, 32'h140);
		rg(1'b1, 16'h0008, 32'h00000140);
		rg(1'b1, 16'h0000, 32'h00000001);
		repeat (300) @(posedge mclk);
		rg(1'b0, 16'h0010, 32'h0); chk(q, 32'h0);
		chk(txq.size(), 0);
		stall = 1'b0;
		poll(16'h0010, 32'h2); chk(q, 32'h2);
		// let the stream fifo drain before counting what left it
		for (i = 0; i < 200 && tx_valid !== 1'b0; i++) @(posedge mclk) #1;
		chk(txq.size(), 19);
		for (i = 0; i < 19 && i < txq.size(); i++) begin
			chk(txq[i][31:0], ex[i]);
			chk({31'h0, txq[i][97]}, i == 0);
			chk({31'h0, txq[i][96]}, i == 18);
			chk({30'h0, txq[i][99:98]}, i == 18 ? 32'h3 : 32'h0);
		end
		chk(txq[0][63:32], uc[31:0]);
		chk(txq[0][95:64], uc[63:32]);
		mr(32'h100); chk(q, st(7'h44, 20'd72));
		mr(32'h120); chk(q, st(7'h24, 20'd3));
		rg(1'b0, 16'h000C, 32'h0); chk(q, 32'h00000140);
		chk(irqs, 1);
		// end address moved on to a descriptor whose buffer lies outside memory
		desc(32'h140, 32'd4, 32'h02000004, 32'h0, 32'h0, 32'h2000, 32'h160);
		rg(1'b1, 16'h0008, 32'h00000160);
		poll(16'h0010, 32'h3); chk(q, 32'h3);
		mr(32'h140); chk({31'h0, q[ERROR_FLAG]}, 32'h1);
		chk({31'h0, q[SHORT_TRANSFER_FLAG]}, 32'h1);
		chk(irqs, 2);
		rg(1'b0, 16'h0000, 32'h0); chk(q, 32'h0);
		$display("tx test done");
		// rx: 11-byte packet into an 8-byte then a 16-byte buffer
		desc(32'h200, 32'h0, 32'h00000008, 32'hA5A5A5A5, 32'h0, 32'h600, 32'h220);
		desc(32'h220, 32'h0, 32'h01000010, 32'h0, 32'hFFFFFFFF, 32'h680, 32'h240);
		rx_us = {32'h0, rnd() | 32'h1};
		rg(1'b1, 16'h0108, 32'h00000240);
		rg(1'b1, 16'h0100, 32'h00000001);
		for (i = 0; i < 3; i++) rw[i] = rnd();
		for (i = 0; i < 3; i++) send(rw[i], i == 2);
		poll(16'h0110, 32'h2); chk(q, 32'h2);
		mr(32'h600); chk(q, rw[0]);
		mr(32'h604); chk(q, rw[1]);
		mr(32'h680); chk(q, rw[2]);
		mr(32'h200); chk(q, st(7'h44, 20'd8));
		mr(32'h208); chk(q, 32'hA5A5A5A5);
		mr(32'h220); chk(q, st(7'h2E, 20'd3));
		mr(32'h228); chk(q, rx_us[31:0]);
		mr(32'h22C); chk(q, 32'h0);
		chk(irqs, 3);
		$display("rx test done");
		end_of_test();
	end
endmodule : tb_top
